// [bench/ppc_periph_model.sv]
// Behavioural model of the external peripheral that watches the port pins
`timescale 1ns/1ns
module ppc_periph_model
    import ppc_pkg::*;
(
    input wire logic aclk,
    input wire logic addr_latch_polarity,
    input wire ppc_pins_t pins,
    output logic [7:0] cap_lo,
    output logic [7:0] cap_wd
);
    // The device knows its strobe polarity only from how the board was set up
    always_ff @(posedge aclk) begin
        if (pins.addr_latch_low_strobe == addr_latch_polarity) begin
            cap_lo <= pins.port_data_bus[7:0];
        end
        // A strobe on an undriven pin is noise, not a write
        if (!pins.write_strobe && !pins.write_oe_n) begin
            cap_wd <= pins.port_data_bus[7:0];
        end
    end
endmodule

// [bench/tb_top.sv]
// Self-checking bench for the parallel port control register and pin logic
`timescale 1ns/1ns
module tb_top;
    import ppc_pkg::*;
    typedef struct packed {
        logic [15:0] ctrl;
        logic [15:0] addr;
        logic [7:0] wd;
        logic [2:0] ph;
        logic [1:0] cs;
        logic [7:0] exp_d;
        logic [5:0] exp_a;
        logic [6:0] exp_c;
    } ppc_row_t;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic device_idle = 0, addr_latch_polarity = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0;
    ppc_req_t req = '0;
    logic awready, wready, bvalid, arready, rvalid, port_active;
    logic [1:0] bresp, rresp, r, r2;
    logic [31:0] rdata, rd;
    logic [7:0] cap_lo, cap_wd;
    logic ibts;
    ppc_pins_t pins;
    int fail_count = 0;
    int check_count = 0;
    // Rows: ctrl, addr, wdata, {lo,hi,wr}, selects, data[7:0], addr[13:8], {oe_n,all,cs1,cs2,wr,woe,roe}
    ppc_row_t rows [5] = '{
        {16'h8280, 16'h1234, 8'hA5, 3'h1, 2'h1, 8'hA5, 6'h12, 7'h29},
        {16'h8A50, 16'h5A3C, 8'h00, 3'h4, 2'h2, 8'h3C, 6'h1A, 7'h1D},
        {16'h9220, 16'h81C3, 8'h00, 3'h2, 2'h0, 8'h81, 6'h00, 7'h0D},
        {16'h9A80, 16'h7F66, 8'h00, 3'h4, 2'h3, 8'h66, 6'h00, 7'h05},
        {16'h8980, 16'h2B3C, 8'h00, 3'h4, 2'h1, 8'h3C, 6'h2B, 7'h0E}};

    ppc_parallel_port_control i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .device_idle(device_idle), .req(req), .port_active(port_active), .input_buffer_type_sel(ibts),
        .pins(pins));
    ppc_periph_model i_periph (.aclk(aclk), .addr_latch_polarity(addr_latch_polarity), .pins(pins), .cap_lo(cap_lo), .cap_wd(cap_wd));

    initial begin
        forever #25 aclk = ~aclk;
    end

    function automatic logic [6:0] ctl();
        return {pins.data_oe_n, pins.addr_latch_low_strobe, pins.chip_select_one, pins.chip_select_two,
                pins.write_strobe, pins.write_oe_n, pins.read_oe_n};
    endfunction

    task automatic complete_run();
        if (fail_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        complete_run();
    end

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk({pins.addr_latch_low_strobe, pins.chip_select_two}, 2'b11);
        @(posedge aclk);
        axr(8'h00, rd, r);
        chk(rd, 32'h0);
        foreach (rows[i]) begin
            axw(8'h00, {16'h0, rows[i].ctrl}, r);
            addr_latch_polarity <= rows[i].ctrl[5];
            req <= {1'b1, rows[i].ph[2:1], 1'b0, rows[i].ph[0], rows[i].cs, rows[i].addr, 8'h00, rows[i].wd};
            @(posedge aclk);
            @(negedge aclk);
            chk({pins.port_data_bus[7:0], pins.port_address_bus[13:8], ctl()},
                {rows[i].exp_d, rows[i].exp_a, rows[i].exp_c});
        end
        req <= '0;
        axw(8'h00, 32'h0000_A200, r);
        device_idle <= 1'b1;
        @(posedge aclk);
        @(negedge aclk);
        chk({cap_lo, cap_wd, port_active}, {16'h3CA5, 1'b0});
        axw(8'h00, 32'h0000_8200, r);
        @(negedge aclk);
        chk(port_active, 1'b1);
        // Turning the port off; the register is left alone for a while afterwards
        axw(8'h00, 32'h0000_02B0, r);
        addr_latch_polarity <= 1'b1;
        repeat (2) @(posedge aclk);
        req <= {1'b1, 2'b10, 1'b0, 1'b1, 2'b11, 16'h1234, 16'h005A};
        @(posedge aclk);
        @(negedge aclk);
        chk({port_active, ctl(), cap_wd}, {1'b0, 7'h55, 8'hA5});
        axw(8'h00, 32'hFFFF_FFFF, r);
        axw(8'h04, 32'h0, r2);
        axr(8'h00, rd, r);
        chk({rd, r, r2, ibts}, {32'h0000_BFF0, 2'h0, PPC_RESP_SLVERR, 1'b1});
        axr(8'h04, rd, r);
        chk({rd, r}, {32'h0, PPC_RESP_SLVERR});
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axr(8'h00, rd, r);
        chk(rd, 32'h0);
        complete_run();
    end
endmodule

// [common/ppc_pkg.sv]
// Package for the parallel port control logic: register map, fields and pin carriers
// How it works
// (RQ1) Enable bit 15 clear: port disabled, no external access at all.
// (RQ2) Idle-stop bit 13 set: port halts while the device idles.
// (RQ3) Mux code 11: lower 8 address bits time-shared on the 16-bit data bus.
// (RQ4) Mux code 10: all 16 address bits time-shared on data pins 7..0.
// (RQ5) Mux code 01: low address on data 7..0, high byte on address pins.
// (RQ6) Mux code 00: address and data on separate pins.
// (RQ7) Bit 9 enables the write/enable strobe pin.
// (RQ8) Bit 8 enables the read/read-write strobe pin.
// (RQ9) Select code 10: both select pins are chip selects; 11 reserved.
// (RQ10) Select code 01: pin one carries address 14, pin two selects.
// (RQ11) Select code 00: pins carry address 14 and 15, no select.
// (RQ12) Bit 5 sets both address latch strobes active high, else low.
// (RQ13) Bit 4 sets the second chip select active high, else low.
// (RQ14) Polarity and select settings never touch pins used as address lines.
// (RQ15) Software avoids register access right after clearing enable at 1:1.
// (RQ16) Bits 31..16 and 14 read zero and ignore writes.
// (RQ17) Disabled port holds strobes and selects at their inactive levels.
package ppc_pkg;
    localparam int PPC_AW = 8;
    localparam logic [PPC_AW-1:0] PPC_CTRL_OFS = 8'h00;
    localparam logic [15:0] PPC_CTRL_RST = 16'h0000;
    localparam logic [15:0] PPC_CTRL_MASK = 16'hBFF0;
    localparam int PPC_ON_BIT = 15;
    localparam int PPC_IDLE_STOP_BIT = 13;
    localparam int PPC_MUX_LSB = 11;
    localparam int PPC_TTL_BIT = 10;
    localparam int PPC_WREN_BIT = 9;
    localparam int PPC_RDEN_BIT = 8;
    localparam int PPC_CSF_LSB = 6;
    localparam int PPC_ALP_BIT = 5;
    localparam int PPC_SECOND_SELECT_POLARITY_BIT = 4;
    localparam logic [1:0] PPC_MUX_NONE = 2'h0;
    localparam logic [1:0] PPC_MUX_SPLIT = 2'h1;
    localparam logic [1:0] PPC_MUX_FULL8 = 2'h2;
    localparam logic [1:0] PPC_MUX_WIDE = 2'h3;
    localparam logic [1:0] PPC_CSF_ADDR = 2'h0;
    localparam logic [1:0] PPC_CSF_MIXED = 2'h1;
    localparam logic [1:0] PPC_RESP_OKAY = 2'h0;
    localparam logic [1:0] PPC_RESP_SLVERR = 2'h2;

    // One access phase as driven by the strobe timing engine
    typedef struct packed {
        logic active;
        logic lo_phase;
        logic hi_phase;
        logic rd;
        logic wr;
        logic [1:0] cs_sel;
        logic [15:0] addr;
        logic [15:0] wdata;
    } ppc_req_t;

    // Pin levels; an _oe_n low means the pin is driven
    typedef struct packed {
        logic [15:0] port_address_bus;
        logic [15:0] port_data_bus;
        logic data_oe_n;
        logic addr_latch_low_strobe;
        logic addr_latch_high_strobe;
        logic chip_select_one;
        logic chip_select_two;
        logic write_strobe;
        logic write_oe_n;
        logic read_strobe;
        logic read_oe_n;
    } ppc_pins_t;
endpackage

// [rtl/ppc_parallel_port_control.sv]
// Parallel port control register with AXI4-Lite access and pin multiplexing
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
module ppc_parallel_port_control
    import ppc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [PPC_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [PPC_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic device_idle,
    input wire ppc_req_t req,
    output logic port_active,
    output logic input_buffer_type_sel,
    output ppc_pins_t pins
);
    typedef struct packed {
        logic [15:0] ctrl;
        logic aw_held;
        logic [PPC_AW-1:0] aw_addr;
        logic w_held;
        logic [15:0] w_data;
        logic [1:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        ppc_pins_t pins;
    } ppc_state_t;

    ppc_state_t cur;
    ppc_state_t next_cur;
    logic run;
    logic [1:0] mux;
    logic [1:0] chip_select_function;
    logic addr_latch_polarity;
    logic second_select_polarity;
    logic addr_phase;
    logic [15:0] wr_val;

    assign mux = cur.ctrl[PPC_MUX_LSB+1:PPC_MUX_LSB];
    assign chip_select_function = cur.ctrl[PPC_CSF_LSB+1:PPC_CSF_LSB];
    assign addr_latch_polarity = cur.ctrl[PPC_ALP_BIT];
    assign second_select_polarity = cur.ctrl[PPC_SECOND_SELECT_POLARITY_BIT];
    // Idle-stop gates the port only while the device actually idles
    assign port_active = cur.ctrl[PPC_ON_BIT] & ~(device_idle & cur.ctrl[PPC_IDLE_STOP_BIT]); // see (RQ1) see (RQ2)
    assign run = port_active & req.active;
    assign addr_phase = req.lo_phase | (req.hi_phase & (mux == PPC_MUX_FULL8));
    assign input_buffer_type_sel = cur.ctrl[PPC_TTL_BIT];

    assign s_axi_awready = ~cur.aw_held & ~cur.bvalid;
    assign s_axi_wready = ~cur.w_held & ~cur.bvalid;
    assign s_axi_bvalid = cur.bvalid;
    assign s_axi_bresp = cur.bresp;
    assign s_axi_arready = ~cur.rvalid;
    assign s_axi_rvalid = cur.rvalid;
    assign s_axi_rresp = cur.rresp;
    assign s_axi_rdata = cur.rdata;
    assign pins = cur.pins;

    always_comb begin
        next_cur = cur;
        wr_val = cur.ctrl;
        // Write channels are taken independently and answered once both are in
        if (s_axi_awvalid && s_axi_awready) begin
            next_cur.aw_held = 1'b1;
            next_cur.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_cur.w_held = 1'b1;
            next_cur.w_data = s_axi_wdata[15:0];
            next_cur.w_strb = s_axi_wstrb[1:0];
        end
        if (cur.aw_held && cur.w_held) begin
            next_cur.aw_held = 1'b0;
            next_cur.w_held = 1'b0;
            next_cur.bvalid = 1'b1;
            if (cur.aw_addr[PPC_AW-1:2] == PPC_CTRL_OFS[PPC_AW-1:2]) begin
                if (cur.w_strb[0]) begin
                    wr_val[7:0] = cur.w_data[7:0];
                end
                if (cur.w_strb[1]) begin
                    wr_val[15:8] = cur.w_data[15:8];
                end
                next_cur.ctrl = wr_val & PPC_CTRL_MASK; // see (RQ16)
                next_cur.bresp = PPC_RESP_OKAY;
            end else begin
                next_cur.bresp = PPC_RESP_SLVERR;
            end
        end
        if (cur.bvalid && s_axi_bready) begin
            next_cur.bvalid = 1'b0;
        end
        if (cur.rvalid && s_axi_rready) begin
            next_cur.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_cur.rvalid = 1'b1;
            if (s_axi_araddr[PPC_AW-1:2] == PPC_CTRL_OFS[PPC_AW-1:2]) begin
                next_cur.rdata = {16'h0000, cur.ctrl}; // see (RQ16)
                next_cur.rresp = PPC_RESP_OKAY;
            end else begin
                next_cur.rdata = 32'h00000000;
                next_cur.rresp = PPC_RESP_SLVERR;
            end
        end

        // Strobe pin drivers follow their enables even while the port is off
        next_cur.pins.write_oe_n = ~cur.ctrl[PPC_WREN_BIT]; // see (RQ7)
        next_cur.pins.read_oe_n = ~cur.ctrl[PPC_RDEN_BIT]; // see (RQ8)
        // Inactive levels first; an access below overrides them
        next_cur.pins.write_strobe = 1'b1; // see (RQ17)
        next_cur.pins.read_strobe = 1'b1;
        next_cur.pins.data_oe_n = 1'b1; // see (RQ1)
        next_cur.pins.addr_latch_low_strobe = ~addr_latch_polarity; // see (RQ12) see (RQ17)
        next_cur.pins.addr_latch_high_strobe = ~addr_latch_polarity;
        if (run) begin
            case (mux)
                PPC_MUX_NONE: begin
                    next_cur.pins.port_address_bus = req.addr; // see (RQ6)
                    next_cur.pins.port_data_bus = req.wdata;
                end
                PPC_MUX_SPLIT: begin
                    next_cur.pins.port_address_bus = {req.addr[15:8], 8'h00}; // see (RQ5)
                    next_cur.pins.port_data_bus = {8'h00, req.lo_phase ? req.addr[7:0] : req.wdata[7:0]};
                end
                PPC_MUX_FULL8: begin
                    next_cur.pins.port_address_bus = 16'h0000;
                    if (req.lo_phase) begin
                        next_cur.pins.port_data_bus = {8'h00, req.addr[7:0]}; // see (RQ4)
                    end else if (req.hi_phase) begin
                        next_cur.pins.port_data_bus = {8'h00, req.addr[15:8]}; // see (RQ4)
                    end else begin
                        next_cur.pins.port_data_bus = {8'h00, req.wdata[7:0]};
                    end
                end
                PPC_MUX_WIDE: begin
                    next_cur.pins.port_address_bus = 16'h0000;
                    next_cur.pins.port_data_bus = req.lo_phase ? {8'h00, req.addr[7:0]} : req.wdata; // see (RQ3)
                end
                default: begin
                    next_cur.pins.port_address_bus = req.addr;
                end
            endcase
            if (req.lo_phase && mux != PPC_MUX_NONE) begin
                next_cur.pins.addr_latch_low_strobe = addr_latch_polarity; // see (RQ12)
            end
            if (req.hi_phase && mux == PPC_MUX_FULL8) begin
                next_cur.pins.addr_latch_high_strobe = addr_latch_polarity;
            end
            next_cur.pins.data_oe_n = ~((addr_phase && mux != PPC_MUX_NONE) || (req.wr && !addr_phase));
            next_cur.pins.write_strobe = ~(req.wr & ~addr_phase);
            next_cur.pins.read_strobe = ~(req.rd & ~addr_phase);
        end

        // Select pins; an address-line pin ignores polarity and cs_sel, and holds while no access runs
        case (chip_select_function)
            PPC_CSF_ADDR: begin
                next_cur.pins.chip_select_one = run ? req.addr[14] : cur.pins.chip_select_one; // see (RQ11) see (RQ14)
                next_cur.pins.chip_select_two = run ? req.addr[15] : cur.pins.chip_select_two; // see (RQ11)
            end
            PPC_CSF_MIXED: begin
                next_cur.pins.chip_select_one = run ? req.addr[14] : cur.pins.chip_select_one; // see (RQ10) see (RQ14)
                next_cur.pins.chip_select_two = (run & req.cs_sel[1]) ? second_select_polarity : ~second_select_polarity; // see (RQ10) see (RQ13)
            end
            default: begin
                // Reserved code 11 behaves as code 10
                next_cur.pins.chip_select_one = ~(run & req.cs_sel[0]); // see (RQ9)
                next_cur.pins.chip_select_two = (run & req.cs_sel[1]) ? second_select_polarity : ~second_select_polarity; // see (RQ9) see (RQ13)
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cur <= '0;
            cur.ctrl <= PPC_CTRL_RST;
            cur.pins.data_oe_n <= 1'b1;
            cur.pins.addr_latch_low_strobe <= 1'b1;
            cur.pins.addr_latch_high_strobe <= 1'b1;
            cur.pins.chip_select_one <= 1'b1;
            cur.pins.chip_select_two <= 1'b1;
            cur.pins.write_strobe <= 1'b1;
            cur.pins.write_oe_n <= 1'b1;
            cur.pins.read_strobe <= 1'b1;
            cur.pins.read_oe_n <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_both_write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_write_answered;
        ##[1:2] s_axi_bvalid;
    endsequence

    a_write_resp_bound: assert property (s_both_write_taken |-> s_write_answered)
        else $error("write response not raised within two cycles");
    a_off_no_access: assert property (!cur.ctrl[PPC_ON_BIT] |=> pins.write_strobe && pins.read_strobe && pins.data_oe_n) // see (RQ1)
        else $error("disabled port drove an access");
    a_idle_halts: assert property (device_idle && cur.ctrl[PPC_IDLE_STOP_BIT] |=> pins.read_strobe && pins.write_strobe) // see (RQ2)
        else $error("port ran during idle with idle-stop set");
    a_wide_addr_out: assert property (run && req.lo_phase && mux == PPC_MUX_WIDE |=> pins.port_data_bus == {8'h00, $past(req.addr[7:0])} && !pins.data_oe_n) // see (RQ3)
        else $error("wide mux address phase wrong");
    a_full8_high_byte: assert property (run && req.hi_phase && !req.lo_phase && mux == PPC_MUX_FULL8 |=> pins.port_data_bus[7:0] == $past(req.addr[15:8])) // see (RQ4)
        else $error("upper address byte not on low data pins");
    a_split_high_pins: assert property (run && mux == PPC_MUX_SPLIT |=> pins.port_address_bus[15:8] == $past(req.addr[15:8])) // see (RQ5)
        else $error("split mux high address pins wrong");
    a_plain_address: assert property (run && mux == PPC_MUX_NONE |=> pins.port_address_bus == $past(req.addr) && pins.port_data_bus == $past(req.wdata)) // see (RQ6)
        else $error("separate address and data pins wrong");
    a_write_pin_en: assert property ($rose(cur.ctrl[PPC_WREN_BIT]) |=> !pins.write_oe_n) // see (RQ7)
        else $error("write strobe pin not enabled");
    a_read_pin_en: assert property ($fell(cur.ctrl[PPC_RDEN_BIT]) |=> pins.read_oe_n) // see (RQ8)
        else $error("read strobe pin not released");
    a_cs_addr_lines: assert property (run && chip_select_function == PPC_CSF_ADDR |=> pins.chip_select_one == $past(req.addr[14]) && pins.chip_select_two == $past(req.addr[15])) // see (RQ11)
        else $error("select pins do not carry address bits");
    a_cs_mixed_map: assert property (run && chip_select_function == PPC_CSF_MIXED |=> pins.chip_select_one == $past(req.addr[14]) && pins.chip_select_two == ($past(req.cs_sel[1]) ? $past(second_select_polarity) : !$past(second_select_polarity))) // see (RQ10) see (RQ13)
        else $error("mixed select mapping wrong");
    a_cs_both_select: assert property (run && chip_select_function[1] && req.cs_sel == 2'h1 |=> !pins.chip_select_one && pins.chip_select_two == !$past(second_select_polarity)) // see (RQ9)
        else $error("dual chip select wrong");
    a_latch_inactive: assert property (!port_active |=> pins.addr_latch_low_strobe == !$past(addr_latch_polarity) && pins.addr_latch_high_strobe == !$past(addr_latch_polarity)) // see (RQ12) see (RQ17)
        else $error("latch strobe not at inactive level");
    a_cs_addr_hold: assert property (!run && chip_select_function == PPC_CSF_ADDR |=> $stable(pins.chip_select_one) && $stable(pins.chip_select_two)) // see (RQ14)
        else $error("address-line select pin moved while idle");
    a_unimpl_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000 && !s_axi_rdata[14] && s_axi_rdata[3:0] == 4'h0) // see (RQ16)
        else $error("unimplemented bits read non-zero");

    // Bus answers; the bench waits for them, so the latency is pinned down here instead
    sequence s_read_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    sequence s_read_answered;
        ##1 s_axi_rvalid;
    endsequence

    a_read_resp_bound: assert property (s_read_taken |-> s_read_answered)
        else $error("read response not raised one cycle after the address");

    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before it was taken");

    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read response changed before it was taken");

    a_ready_after_resp: assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready)
        else $error("write channels not free after the response");

    a_aw_wait_resp: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channel open while a response is pending");

    a_ar_wait_resp: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while a response is pending");

    a_slverr_rdata: assert property (s_axi_rvalid && s_axi_rresp == PPC_RESP_SLVERR |-> s_axi_rdata == 32'h00000000) // see (RQ16)
        else $error("refused read returned data");

    a_rresp_code: assert property (s_axi_rvalid |-> s_axi_rresp == PPC_RESP_OKAY || s_axi_rresp == PPC_RESP_SLVERR)
        else $error("read response code out of range");

    a_bresp_code: assert property (s_axi_bvalid |-> s_axi_bresp == PPC_RESP_OKAY || s_axi_bresp == PPC_RESP_SLVERR)
        else $error("write response code out of range");

    // Unwritable bits must never latch, whatever software writes
    a_ctrl_unimpl: assert property ((cur.ctrl & ~PPC_CTRL_MASK) == 16'h0000) // see (RQ16)
        else $error("unimplemented control bit became set");

    // Address latch strobes follow the polarity bit in both states
    a_low_latch_act: assert property (run && req.lo_phase && mux != PPC_MUX_NONE |=> pins.addr_latch_low_strobe == $past(addr_latch_polarity)) // see (RQ12)
        else $error("low address latch strobe not active");

    a_high_latch_act: assert property (run && req.hi_phase && mux == PPC_MUX_FULL8 |=> pins.addr_latch_high_strobe == $past(addr_latch_polarity)) // see (RQ12)
        else $error("high address latch strobe not active");

    a_high_latch_idle: assert property (run && mux != PPC_MUX_FULL8 |=> pins.addr_latch_high_strobe == !$past(addr_latch_polarity)) // see (RQ12)
        else $error("high address latch strobe active outside mux 10");

    a_plain_no_latch: assert property (run && mux == PPC_MUX_NONE |=> pins.addr_latch_low_strobe == !$past(addr_latch_polarity) && pins.addr_latch_high_strobe == !$past(addr_latch_polarity)) // see (RQ6)
        else $error("latch strobe pulsed with separate pins");

    // Data and address pin contents per multiplexing scheme
    a_wide_data_phase: assert property (run && !req.lo_phase && mux == PPC_MUX_WIDE |=> pins.port_data_bus == $past(req.wdata)) // see (RQ3)
        else $error("wide mux data phase wrong");

    a_full8_low_byte: assert property (run && req.lo_phase && mux == PPC_MUX_FULL8 |=> pins.port_data_bus == {8'h00, $past(req.addr[7:0])}) // see (RQ4)
        else $error("lower address byte not on low data pins");

    a_split_low_byte: assert property (run && req.lo_phase && mux == PPC_MUX_SPLIT |=> pins.port_data_bus == {8'h00, $past(req.addr[7:0])}) // see (RQ5)
        else $error("split mux low address byte wrong");

    a_split_low_pins: assert property (run && mux == PPC_MUX_SPLIT |=> pins.port_address_bus[7:0] == 8'h00) // see (RQ5)
        else $error("split mux low address pins not quiet");

    a_mux_addr_zero: assert property (run && (mux == PPC_MUX_FULL8 || mux == PPC_MUX_WIDE) |=> pins.port_address_bus == 16'h0000) // see (RQ4)
        else $error("address pins driven in a data-bus multiplexing mode");

    a_mux_addr_oe: assert property (run && addr_phase && mux != PPC_MUX_NONE |=> !pins.data_oe_n) // see (RQ4)
        else $error("data pins not driven in address phase");

    a_plain_addr_oe: assert property (run && mux == PPC_MUX_NONE && !req.wr |=> pins.data_oe_n) // see (RQ6)
        else $error("data pins driven without a write on separate pins");

    // Strobes only in the data phase of an enabled access
    a_wr_strobe: assert property (run && req.wr && !addr_phase |=> !pins.write_strobe && !pins.data_oe_n) // see (RQ1)
        else $error("write strobe missing in data phase");

    a_rd_strobe: assert property (run && req.rd && !addr_phase |=> !pins.read_strobe) // see (RQ1)
        else $error("read strobe missing in data phase");

    a_addr_no_strobe: assert property (run && addr_phase |=> pins.write_strobe && pins.read_strobe) // see (RQ1)
        else $error("strobe active during an address phase");

    // A stopped port leaves every select and the data bus quiet
    a_off_cs_inactive: assert property (!port_active && chip_select_function[1] |=> pins.chip_select_one && pins.chip_select_two == !$past(second_select_polarity)) // see (RQ17)
        else $error("chip select active while port stopped");

    a_mixed_cs2_off: assert property (!port_active && chip_select_function == PPC_CSF_MIXED |=> pins.chip_select_two == !$past(second_select_polarity)) // see (RQ17)
        else $error("second select active while port stopped");

    a_data_hiz_off: assert property (!port_active |=> pins.data_oe_n) // see (RQ1)
        else $error("data pins driven while port stopped");

    a_idle_data_float: assert property (device_idle && cur.ctrl[PPC_IDLE_STOP_BIT] |=> pins.data_oe_n) // see (RQ2)
        else $error("data pins driven during idle with idle-stop set");

    a_write_pin_off: assert property ($fell(cur.ctrl[PPC_WREN_BIT]) |=> pins.write_oe_n) // see (RQ7)
        else $error("write strobe pin not released");

    a_read_pin_on: assert property ($rose(cur.ctrl[PPC_RDEN_BIT]) |=> !pins.read_oe_n) // see (RQ8)
        else $error("read strobe pin not enabled");
endmodule
